// ### pkg/fsre_pkg.sv
// constants shared by the fieldbus slave error reporting block
// Behaviour
// RQ1: inverter trip forces fault state in status
// RQ2: fault cleared by reset bit once cause gone
// RQ3: inverter warning sets status word bit 7
// RQ4: bit 9 cleared when network control impossible
// RQ5: emergency on trip or warning, not comms
// RQ6: detected error code posted to error register
// RQ7: inverter current error readable by software
// RQ8: diagnosis history keeps last eight errors
// RQ9: status codes none, internal failure, no memory
// RQ10: illegal transition refused, code 0x0011
// RQ11: undefined target state gives code 0x0012
// RQ12: mailbox faults give codes 0x0015, 0x0016
// RQ13: process data watchdog timeout gives 0x001B
// RQ14: bad watchdog setting rejected, code 0x001F
// RQ15: tx/rx mapping faults give 0x0024, 0x0025
// RQ16: sync data loss in operational gives 0x002C
// RQ17: config error blinks indicator 200 ms phases
// RQ18: timeout double flashes, then 1000 ms off
// RQ19: status code held until acked or replaced
package fsre_pkg;
	// ========================================
	// timing
	localparam int CLK_KHZ         = 100_000;
	localparam int T_LED_PH_MS     = 200;
	localparam int T_LED_LONG_MS   = 1000;
	localparam int T_WDT_MS        = 100;
	localparam int T_SYNC_MS       = 10;
	localparam int LED_PH_CYC      = T_LED_PH_MS * CLK_KHZ;
	localparam int LED_LONG_CYC    = T_LED_LONG_MS * CLK_KHZ;
	localparam int WDT_CYC         = T_WDT_MS * CLK_KHZ;
	localparam int SYNC_CYC        = T_SYNC_MS * CLK_KHZ;
	// ========================================
	// register offsets (byte addresses)
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_ERRC   = 8'h08;
	localparam logic [7:0] A_INVERR = 8'h0C;
	localparam logic [7:0] A_ALSTAT = 8'h10;
	localparam logic [7:0] A_ALST   = 8'h14;
	localparam logic [7:0] A_WDT    = 8'h18;
	localparam logic [7:0] A_SYNC   = 8'h1C;
	localparam logic [7:0] A_DCNT   = 8'h20;
	localparam logic [2:0] A_DIAG_HI = 3'h2;
	// ========================================
	// field positions
	localparam int CW_FRESET = 7;
	localparam int SW_FAULT  = 3;
	localparam int SW_WARN   = 7;
	localparam int SW_REMOTE = 9;
	localparam int DIAG_N    = 8;
	localparam logic [3:0] DIAG_MAX = 4'h8;
	// ========================================
	// status codes
	localparam logic [15:0] AL_OK       = 16'h0000;
	localparam logic [15:0] AL_UNDEF    = 16'h0001;
	localparam logic [15:0] AL_NOMEM    = 16'h0002;
	localparam logic [15:0] AL_BADTR    = 16'h0011;
	localparam logic [15:0] AL_UNKST    = 16'h0012;
	localparam logic [15:0] AL_MBXRX    = 16'h0015;
	localparam logic [15:0] AL_MBXSET   = 16'h0016;
	localparam logic [15:0] AL_WDTO     = 16'h001B;
	localparam logic [15:0] AL_WDTCFG   = 16'h001F;
	localparam logic [15:0] AL_TXMAP    = 16'h0024;
	localparam logic [15:0] AL_RXMAP    = 16'h0025;
	localparam logic [15:0] AL_SYNC     = 16'h002C;
	localparam logic [15:0] COMM_ERR_CODE = 16'h7500;
	// ========================================
	// requested state encodings
	localparam logic [3:0] RQ_INIT   = 4'h1;
	localparam logic [3:0] RQ_PREOP  = 4'h2;
	localparam logic [3:0] RQ_BOOT   = 4'h3;
	localparam logic [3:0] RQ_SAFEOP = 4'h4;
	localparam logic [3:0] RQ_OP     = 4'h8;

	typedef enum logic [2:0] {
		ST_INIT   = 3'b000,
		ST_PREOP  = 3'b001,
		ST_SAFEOP = 3'b011,
		ST_OP     = 3'b010,
		ST_BOOT   = 3'b110
	} fsre_al_st_t;

	typedef enum logic [1:0] {
		LED_OFF   = 2'b00,
		LED_BLINK = 2'b01,
		LED_DFL   = 2'b11
	} fsre_led_t;
endpackage

// ### core/fsre_led.sv
// error indicator pattern generator
`timescale 1ns/10ps
module fsre_led #(
	parameter int PH_CYC   = fsre_pkg::LED_PH_CYC,
	parameter int LONG_CYC = fsre_pkg::LED_LONG_CYC
) (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire fsre_pkg::fsre_led_t mode,
	output logic                  led_ff
);
	// ========================================
	// state
	typedef struct packed {
		logic [31:0]         cnt;
		logic [1:0]          step;
		logic                led;
		fsre_pkg::fsre_led_t mode_q;
	} fsre_led_st_t;

	fsre_led_st_t s_ff;
	fsre_led_st_t nxt_s;
	logic [31:0]  lim;

	always_comb begin
		nxt_s = s_ff;
		lim = (s_ff.step == 2'd3) ? 32'(LONG_CYC - 1) : 32'(PH_CYC - 1);
		nxt_s.mode_q = mode;
		if (mode != s_ff.mode_q) begin
			// restart pattern so a new blink or double flash mode starts with a full on phase
			nxt_s.cnt = '0;
			nxt_s.step = '0;
			nxt_s.led = (mode != fsre_pkg::LED_OFF);
		end else begin
			case (mode)
				fsre_pkg::LED_BLINK: begin
					if (s_ff.cnt == 32'(PH_CYC - 1)) begin
						nxt_s.cnt = '0;
						nxt_s.led = ~s_ff.led; // see RQ17
					end else begin
						nxt_s.cnt = s_ff.cnt + 32'd1;
					end
				end
				fsre_pkg::LED_DFL: begin
					if (s_ff.cnt == lim) begin
						nxt_s.cnt = '0;
						nxt_s.step = s_ff.step + 2'd1;
						nxt_s.led = ~nxt_s.step[0]; // see RQ18
					end else begin
						nxt_s.cnt = s_ff.cnt + 32'd1;
					end
				end
				default: begin
					nxt_s.cnt = '0;
					nxt_s.step = '0;
					nxt_s.led = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign led_ff = s_ff.led;

	// ========================================
	// checks
	AST_LED_BLINK: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ17
		(mode == fsre_pkg::LED_BLINK && s_ff.mode_q == fsre_pkg::LED_BLINK &&
		s_ff.cnt == 32'(PH_CYC - 1) && $stable(mode)) |=> (led_ff != $past(led_ff)))
		else $error("blink phase did not toggle");
	AST_LED_DFL: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ18
		(mode == fsre_pkg::LED_DFL && s_ff.mode_q == fsre_pkg::LED_DFL)
		|-> (led_ff == ~s_ff.step[0]))
		else $error("double flash pattern out of step");
endmodule

// ### core/fsre_top.sv
// error and status reporting of the fieldbus slave adapter
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module fsre_top #(
	parameter int WDT_DEF  = fsre_pkg::WDT_CYC,
	parameter int SYNC_DEF = fsre_pkg::SYNC_CYC,
	parameter int PH_CYC   = fsre_pkg::LED_PH_CYC,
	parameter int LONG_CYC = fsre_pkg::LED_LONG_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        inv_trip,
	input  wire logic        inv_warn,
	input  wire logic [15:0] inv_err_code,
	input  wire logic [2:0]  local_override,
	input  wire logic        inv_link_ok,
	input  wire logic        comm_err,
	input  wire logic        int_fail,
	input  wire logic        mem_short,
	input  wire logic        mbx_rx_err,
	input  wire logic        mbx_set_err,
	input  wire logic        txmap_err,
	input  wire logic        rxmap_err,
	input  wire logic        al_req_valid,
	input  wire logic [3:0]  al_req_state,
	input  wire logic        rxpdo_seen,
	input  wire logic        sync_seen,
	output logic      [15:0] drv_status,
	output logic      [15:0] al_status,
	output logic      [3:0]  al_state,
	output logic             emcy_valid,
	output logic      [15:0] emcy_code,
	output logic             err_led
);
	// ========================================
	// state
	typedef struct packed {
		logic                      trip_q;
		logic                      warn_q;
		logic                      fault;
		logic [15:0]               sw;
		logic [15:0]               err_code;
		logic [15:0]               inv_err;
		logic [15:0]               al_code;
		fsre_pkg::fsre_al_st_t     al_st;
		logic [3:0]                al_enc;
		logic [31:0]               wdt_per;
		logic [31:0]               sync_per;
		logic [31:0]               wdt_cnt;
		logic [31:0]               sync_cnt;
		logic [7:0][15:0]          diag;
		logic [2:0]                diag_wp;
		logic [3:0]                diag_cnt;
		logic                      emcy_v;
		logic [15:0]               emcy_c;
		logic [31:0]               rdata;
		fsre_pkg::fsre_led_t       led_mode;
	} fsre_st_t;

	fsre_st_t              s_ff;
	fsre_st_t              nxt_s;
	logic                  trip_rise;
	logic                  warn_rise;
	logic                  al_hit;
	logic [15:0]           al_val;
	logic                  rec;
	logic [15:0]           rec_val;
	logic                  req_ok;
	fsre_pkg::fsre_al_st_t req_st;

	function automatic logic fsre_allowed(fsre_pkg::fsre_al_st_t c,
		fsre_pkg::fsre_al_st_t t);
		logic ok;
		ok = 1'b0;
		case (c)
			fsre_pkg::ST_INIT: ok = (t != fsre_pkg::ST_SAFEOP) &&
				(t != fsre_pkg::ST_OP);
			fsre_pkg::ST_PREOP: ok = (t == fsre_pkg::ST_INIT) ||
				(t == fsre_pkg::ST_PREOP) || (t == fsre_pkg::ST_SAFEOP);
			fsre_pkg::ST_SAFEOP: ok = (t != fsre_pkg::ST_BOOT);
			fsre_pkg::ST_OP: ok = (t != fsre_pkg::ST_BOOT);
			fsre_pkg::ST_BOOT: ok = (t == fsre_pkg::ST_INIT) ||
				(t == fsre_pkg::ST_BOOT);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic [3:0] fsre_enc(fsre_pkg::fsre_al_st_t st);
		logic [3:0] e;
		e = fsre_pkg::RQ_INIT;
		case (st)
			fsre_pkg::ST_PREOP: e = fsre_pkg::RQ_PREOP;
			fsre_pkg::ST_SAFEOP: e = fsre_pkg::RQ_SAFEOP;
			fsre_pkg::ST_OP: e = fsre_pkg::RQ_OP;
			fsre_pkg::ST_BOOT: e = fsre_pkg::RQ_BOOT;
			default: e = fsre_pkg::RQ_INIT;
		endcase
		return e;
	endfunction

	// ========================================
	// next state
	always_comb begin
		nxt_s = s_ff;
		nxt_s.emcy_v = 1'b0;
		nxt_s.rdata = '0;
		trip_rise = inv_trip & ~s_ff.trip_q;
		warn_rise = inv_warn & ~s_ff.warn_q;
		nxt_s.trip_q = inv_trip;
		nxt_s.warn_q = inv_warn;
		nxt_s.inv_err = inv_err_code; // see RQ7
		al_hit = 1'b0;
		al_val = fsre_pkg::AL_OK;
		rec = 1'b0;
		rec_val = '0;
		req_ok = 1'b1;
		req_st = fsre_pkg::ST_INIT;

		// register writes
		if (reg_wr) begin
			if (reg_addr == fsre_pkg::A_CTRL) begin
				if (reg_wdata[fsre_pkg::CW_FRESET] && !inv_trip) begin
					nxt_s.fault = 1'b0; // see RQ2
				end
			end else if (reg_addr == fsre_pkg::A_ALSTAT) begin
				nxt_s.al_code = fsre_pkg::AL_OK; // see RQ19
			end else if (reg_addr == fsre_pkg::A_WDT) begin
				if (reg_wdata == '0) begin
					al_hit = 1'b1; // see RQ14
					al_val = fsre_pkg::AL_WDTCFG;
				end else begin
					nxt_s.wdt_per = reg_wdata;
				end
			end else if (reg_addr == fsre_pkg::A_SYNC) begin
				if (reg_wdata != '0) begin
					nxt_s.sync_per = reg_wdata;
				end
			end
		end
		// set wins over a same-cycle fault reset
		if (inv_trip) begin
			nxt_s.fault = 1'b1; // see RQ1
		end

		// lower priority first, later lines override
		if (mem_short) begin
			al_hit = 1'b1; // see RQ9
			al_val = fsre_pkg::AL_NOMEM;
		end
		if (int_fail) begin
			al_hit = 1'b1; // see RQ9
			al_val = fsre_pkg::AL_UNDEF;
		end
		if (rxmap_err) begin
			al_hit = 1'b1; // see RQ15
			al_val = fsre_pkg::AL_RXMAP;
		end
		if (txmap_err) begin
			al_hit = 1'b1; // see RQ15
			al_val = fsre_pkg::AL_TXMAP;
		end
		if (mbx_set_err) begin
			al_hit = 1'b1; // see RQ12
			al_val = fsre_pkg::AL_MBXSET;
		end
		if (mbx_rx_err) begin
			al_hit = 1'b1; // see RQ12
			al_val = fsre_pkg::AL_MBXRX;
		end

		// process data supervision, only in operational
		nxt_s.wdt_cnt = '0;
		nxt_s.sync_cnt = '0;
		if (s_ff.al_st == fsre_pkg::ST_OP) begin
			if (!sync_seen) begin
				nxt_s.sync_cnt = s_ff.sync_cnt + 32'd1;
			end
			if (!rxpdo_seen) begin
				nxt_s.wdt_cnt = s_ff.wdt_cnt + 32'd1;
			end
			if (!sync_seen && s_ff.sync_cnt == s_ff.sync_per - 32'd1) begin
				al_hit = 1'b1; // see RQ16
				al_val = fsre_pkg::AL_SYNC;
				nxt_s.al_st = fsre_pkg::ST_SAFEOP;
			end
			if (!rxpdo_seen && s_ff.wdt_cnt == s_ff.wdt_per - 32'd1) begin
				al_hit = 1'b1; // see RQ13
				al_val = fsre_pkg::AL_WDTO;
				nxt_s.al_st = fsre_pkg::ST_SAFEOP;
			end
		end

		// transition requests rank highest
		if (al_req_valid) begin
			if (al_req_state == fsre_pkg::RQ_INIT) begin
				req_st = fsre_pkg::ST_INIT;
			end else if (al_req_state == fsre_pkg::RQ_PREOP) begin
				req_st = fsre_pkg::ST_PREOP;
			end else if (al_req_state == fsre_pkg::RQ_BOOT) begin
				req_st = fsre_pkg::ST_BOOT;
			end else if (al_req_state == fsre_pkg::RQ_SAFEOP) begin
				req_st = fsre_pkg::ST_SAFEOP;
			end else if (al_req_state == fsre_pkg::RQ_OP) begin
				req_st = fsre_pkg::ST_OP;
			end else begin
				req_ok = 1'b0;
			end
			if (!req_ok) begin
				al_hit = 1'b1; // see RQ11
				al_val = fsre_pkg::AL_UNKST;
				nxt_s.al_st = s_ff.al_st;
			end else if (!fsre_allowed(s_ff.al_st, req_st)) begin
				al_hit = 1'b1; // see RQ10
				al_val = fsre_pkg::AL_BADTR;
				nxt_s.al_st = s_ff.al_st;
			end else begin
				nxt_s.al_st = req_st;
			end
		end
		nxt_s.al_enc = fsre_enc(nxt_s.al_st);
		// new error wins over a same-cycle acknowledge
		if (al_hit) begin
			nxt_s.al_code = al_val; // see RQ19
		end

		// error recording, inverter trip or warning ranks highest
		if (al_hit) begin
			rec = 1'b1;
			rec_val = al_val;
		end
		if (comm_err) begin
			rec = 1'b1;
			rec_val = fsre_pkg::COMM_ERR_CODE;
		end
		if (warn_rise || trip_rise) begin
			rec = 1'b1;
			rec_val = inv_err_code;
		end
		if (rec) begin
			nxt_s.err_code = rec_val; // see RQ6
			nxt_s.diag[s_ff.diag_wp] = rec_val; // see RQ8
			nxt_s.diag_wp = s_ff.diag_wp + 3'd1;
			if (s_ff.diag_cnt != fsre_pkg::DIAG_MAX) begin
				nxt_s.diag_cnt = s_ff.diag_cnt + 4'd1;
			end
		end
		// communication errors raise no emergency
		if (trip_rise || warn_rise) begin
			nxt_s.emcy_v = 1'b1; // see RQ5
			nxt_s.emcy_c = inv_err_code;
		end

		nxt_s.sw = '0;
		nxt_s.sw[fsre_pkg::SW_FAULT] = nxt_s.fault; // see RQ1
		nxt_s.sw[fsre_pkg::SW_WARN] = inv_warn; // see RQ3
		nxt_s.sw[fsre_pkg::SW_REMOTE] = inv_link_ok &&
			(local_override == 3'b000); // see RQ4

		case (nxt_s.al_code)
			fsre_pkg::AL_MBXRX, fsre_pkg::AL_MBXSET, fsre_pkg::AL_WDTCFG,
			fsre_pkg::AL_TXMAP, fsre_pkg::AL_RXMAP:
				nxt_s.led_mode = fsre_pkg::LED_BLINK; // see RQ17
			fsre_pkg::AL_WDTO:
				nxt_s.led_mode = fsre_pkg::LED_DFL; // see RQ18
			default:
				nxt_s.led_mode = fsre_pkg::LED_OFF;
		endcase

		// reads answer one cycle later, unmapped reads zero
		if (reg_rd) begin
			if (reg_addr == fsre_pkg::A_CTRL) begin
				nxt_s.rdata = '0;
			end else if (reg_addr == fsre_pkg::A_STATUS) begin
				nxt_s.rdata = {16'h0000, s_ff.sw};
			end else if (reg_addr == fsre_pkg::A_ERRC) begin
				nxt_s.rdata = {16'h0000, s_ff.err_code};
			end else if (reg_addr == fsre_pkg::A_INVERR) begin
				nxt_s.rdata = {16'h0000, s_ff.inv_err};
			end else if (reg_addr == fsre_pkg::A_ALSTAT) begin
				nxt_s.rdata = {16'h0000, s_ff.al_code};
			end else if (reg_addr == fsre_pkg::A_ALST) begin
				nxt_s.rdata = {28'h000_0000, s_ff.al_enc};
			end else if (reg_addr == fsre_pkg::A_WDT) begin
				nxt_s.rdata = s_ff.wdt_per;
			end else if (reg_addr == fsre_pkg::A_SYNC) begin
				nxt_s.rdata = s_ff.sync_per;
			end else if (reg_addr == fsre_pkg::A_DCNT) begin
				nxt_s.rdata = {25'h0, s_ff.diag_wp, s_ff.diag_cnt};
			end else if (reg_addr[7:5] == fsre_pkg::A_DIAG_HI) begin
				nxt_s.rdata = {16'h0000, s_ff.diag[reg_addr[4:2]]};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_ff <= '0;
			s_ff.wdt_per <= 32'(WDT_DEF);
			s_ff.sync_per <= 32'(SYNC_DEF);
			s_ff.al_enc <= fsre_pkg::RQ_INIT;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign reg_rdata = s_ff.rdata;
	assign drv_status = s_ff.sw;
	assign al_status = s_ff.al_code;
	assign al_state = s_ff.al_enc;
	assign emcy_valid = s_ff.emcy_v;
	assign emcy_code = s_ff.emcy_c;

	fsre_led #(
		.PH_CYC   (PH_CYC),
		.LONG_CYC (LONG_CYC)
	) u_led (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.mode    (s_ff.led_mode),
		.led_ff  (err_led)
	);

	// ========================================
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	AST_FAULT_SET: assert property (inv_trip |=> drv_status[3]) // see RQ1
		else $error("trip did not raise fault");
	AST_FAULT_HOLD: assert property (drv_status[3] && // see RQ2
		!(reg_wr && reg_addr == fsre_pkg::A_CTRL && reg_wdata[7]) |=> drv_status[3])
		else $error("fault left without reset bit");
	AST_WARN: assert property (drv_status[7] == $past(inv_warn)) // see RQ3
		else $error("warning bit wrong");
	AST_REMOTE: assert property ((local_override != 3'b000 || !inv_link_ok) // see RQ4
		|=> !drv_status[9])
		else $error("remote bit set while control impossible");
	AST_EMCY: assert property ($rose(inv_trip) |=> emcy_valid && // see RQ5
		emcy_code == $past(inv_err_code))
		else $error("no emergency on trip");
	AST_NO_EMCY: assert property (comm_err && !$rose(inv_trip) && // see RQ5
		!$rose(inv_warn) |=> !emcy_valid)
		else $error("emergency on communication error");
	AST_ERRC: assert property ($rose(inv_trip) // see RQ6
		|=> s_ff.err_code == $past(inv_err_code))
		else $error("error code not posted");
	AST_DIAG: assert property (s_ff.diag_cnt <= 4'd8) // see RQ8
		else $error("history count beyond eight");
	AST_UNKST: assert property (al_req_valid && !(al_req_state inside // see RQ11
		{4'h1, 4'h2, 4'h3, 4'h4, 4'h8}) |=> al_status == 16'h0012 && $stable(al_state))
		else $error("undefined target not reported");
	AST_BADTR: assert property (al_req_valid && s_ff.al_st == fsre_pkg::ST_INIT // see RQ10
		&& al_req_state == 4'h8 |=> al_status == 16'h0011 && al_state == 4'h1)
		else $error("illegal transition not refused");
	AST_WDTO: assert property (s_ff.al_st == fsre_pkg::ST_OP && // see RQ13
		!rxpdo_seen && !al_req_valid && s_ff.wdt_cnt == s_ff.wdt_per - 32'd1
		|=> al_status == 16'h001B ##1 err_led)
		else $error("watchdog timeout not reported");
	AST_HOLD: assert property (al_status != 16'h0000 && !al_hit && // see RQ19
		!(reg_wr && reg_addr == fsre_pkg::A_ALSTAT) |=> $stable(al_status))
		else $error("status code changed without cause");
endmodule

// ### tb/fsre_master.sv
// network master model: process data and sync refresh
`timescale 1ns/10ps
module fsre_master #(
	parameter int GAP = 5
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic pdo_en,
	input  wire logic sync_en,
	output logic      rxpdo_seen,
	output logic      sync_seen
);
	// ========================================
	// refresh pacing
	logic [7:0] cnt_ff;

	// refresh pulses only while enabled, so silence is a real outage
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_ff     <= 8'h00;
			rxpdo_seen <= 1'b0;
			sync_seen  <= 1'b0;
		end else begin
			cnt_ff     <= (cnt_ff == 8'(GAP - 1)) ? 8'h00 : cnt_ff + 8'h01;
			rxpdo_seen <= pdo_en && (cnt_ff == 8'h00);
			sync_seen  <= sync_en && (cnt_ff == 8'h00);
		end
	end
endmodule

// ### tb/fsre_tb_top.sv
// self-checking bench of the error reporting block
`timescale 1ns/10ps
module fsre_tb_top;
	// ========================================
	// signals
	localparam int WDT = 20;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        inv_trip = 1'b0;
	logic        inv_warn = 1'b0;
	logic [15:0] inv_err_code = 16'h0000;
	logic [2:0]  local_override = 3'h0;
	logic        inv_link_ok = 1'b1;
	logic [6:0]  errs = 7'h00;
	logic        al_req_valid = 1'b0;
	logic [3:0]  al_req_state = 4'h0;
	logic        pdo_en = 1'b0;
	logic        sync_en = 1'b0;
	logic        rxpdo_seen, sync_seen, emcy_valid, err_led;
	logic [15:0] drv_status, al_status, emcy_code;
	logic [3:0]  al_state;
	logic [31:0] reg_rdata, q;
	int          miscompares = 0;
	int          check_count = 0;

	always #5 clk_sys = ~clk_sys;

	fsre_top #(.WDT_DEF(WDT), .SYNC_DEF(30), .PH_CYC(4), .LONG_CYC(10))
	i_fsre_top (
		.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .inv_trip(inv_trip), .inv_warn(inv_warn),
		.inv_err_code(inv_err_code), .local_override(local_override),
		.inv_link_ok(inv_link_ok), .comm_err(errs[6]), .int_fail(errs[0]),
		.mem_short(errs[1]), .mbx_rx_err(errs[2]), .mbx_set_err(errs[3]),
		.txmap_err(errs[4]), .rxmap_err(errs[5]),
		.al_req_valid(al_req_valid), .al_req_state(al_req_state),
		.rxpdo_seen(rxpdo_seen), .sync_seen(sync_seen),
		.drv_status(drv_status), .al_status(al_status), .al_state(al_state),
		.emcy_valid(emcy_valid), .emcy_code(emcy_code), .err_led(err_led));

	fsre_master #(.GAP(5)) i_fsre_master (
		.clk_sys(clk_sys), .rstn(rstn), .pdo_en(pdo_en),
		.sync_en(sync_en), .rxpdo_seen(rxpdo_seen), .sync_seen(sync_seen));

	// ========================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		q = reg_rdata;
	endtask
	task automatic pulse(input logic [6:0] m);
		@(posedge clk_sys);
		errs <= m;
		@(posedge clk_sys);
		errs <= 7'h00;
		#1;
	endtask
	task automatic req(input logic [3:0] s);
		@(posedge clk_sys);
		al_req_valid <= 1'b1;
		al_req_state <= s;
		@(posedge clk_sys);
		al_req_valid <= 1'b0;
		#1;
	endtask
	task automatic wait_code(input logic [15:0] c);
		int k;
		k = 0;
		while (al_status !== c && k < 100) begin
			step;
			k++;
		end
	endtask
	// windows are whole pattern periods, so the phase does not matter
	task automatic led_cnt(input int n, input int exp);
		int h;
		h = 0;
		repeat (n) begin
			step;
			h += int'(err_led);
		end
		chk(h, exp);
	endtask

	// ========================================
	// scenarios
	task automatic t_trip;
		@(posedge clk_sys);
		inv_trip     <= 1'b1;
		inv_err_code <= 16'h0123;
		step;
		chk(drv_status[fsre_pkg::SW_FAULT], 1'b1);
		chk({emcy_valid, emcy_code}, {1'b1, 16'h0123});
		wr(fsre_pkg::A_CTRL, 32'h0000_0080);
		chk(drv_status[fsre_pkg::SW_FAULT], 1'b1);
		rd(fsre_pkg::A_ERRC);
		chk(q, 32'h0000_0123);
		@(posedge clk_sys);
		inv_err_code <= 16'h0456;
		rd(fsre_pkg::A_INVERR);
		chk(q, 32'h0000_0456);
		@(posedge clk_sys);
		inv_trip <= 1'b0;
		wr(fsre_pkg::A_CTRL, 32'h0000_0080);
		chk(drv_status[fsre_pkg::SW_FAULT], 1'b0);
	endtask
	task automatic t_warn;
		@(posedge clk_sys);
		inv_warn     <= 1'b1;
		inv_err_code <= 16'h0321;
		step;
		chk({drv_status[fsre_pkg::SW_WARN], emcy_valid}, 2'b11);
		pulse(7'h40);
		chk(emcy_valid, 1'b0);
		@(posedge clk_sys);
		inv_warn <= 1'b0;
		step;
		chk(drv_status[fsre_pkg::SW_WARN], 1'b0);
	endtask
	task automatic t_remote;
		chk(drv_status[fsre_pkg::SW_REMOTE], 1'b1);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			local_override <= (i < 3) ? 3'b001 << i : 3'b000;
			inv_link_ok    <= (i < 3);
			step;
			chk(drv_status[fsre_pkg::SW_REMOTE], 1'b0);
			@(posedge clk_sys);
			local_override <= 3'b000;
			inv_link_ok    <= 1'b1;
		end
	endtask
	task automatic t_codes;
		logic [15:0] c [6];
		c = '{fsre_pkg::AL_UNDEF, fsre_pkg::AL_NOMEM, fsre_pkg::AL_MBXRX,
			fsre_pkg::AL_MBXSET, fsre_pkg::AL_TXMAP, fsre_pkg::AL_RXMAP};
		for (int i = 0; i < 6; i++) begin
			pulse(7'h01 << i);
			chk(al_status, c[i]);
			step;
			chk(al_status, c[i]);
			wr(fsre_pkg::A_ALSTAT, 32'h0000_0000);
			chk(al_status, fsre_pkg::AL_OK);
		end
		pulse(7'h14);
		chk(al_status, fsre_pkg::AL_MBXRX);
		pulse(7'h20);
		chk(al_status, fsre_pkg::AL_RXMAP);
	endtask
	task automatic t_wdtcfg;
		wr(fsre_pkg::A_WDT, 32'h0000_0000);
		chk(al_status, fsre_pkg::AL_WDTCFG);
		rd(fsre_pkg::A_WDT);
		chk(q, WDT);
		wr(fsre_pkg::A_SYNC, 32'h0000_0000);
		rd(fsre_pkg::A_SYNC);
		chk(q, 32'h0000_001E);
		led_cnt(40, 20);
		wr(fsre_pkg::A_ALSTAT, 32'h0000_0000);
	endtask
	task automatic t_state;
		req(fsre_pkg::RQ_OP);
		chk({al_status, al_state}, {fsre_pkg::AL_BADTR, 4'h1});
		wr(fsre_pkg::A_ALSTAT, 32'h0000_0000);
		req(4'h5);
		chk(al_status, fsre_pkg::AL_UNKST);
		wr(fsre_pkg::A_ALSTAT, 32'h0000_0000);
		@(posedge clk_sys);
		pdo_en  <= 1'b1;
		sync_en <= 1'b1;
		req(fsre_pkg::RQ_PREOP);
		req(fsre_pkg::RQ_SAFEOP);
		req(fsre_pkg::RQ_OP);
		repeat (60) step;
		chk({al_status, al_state}, {16'h0000, 4'h8});
		@(posedge clk_sys);
		pdo_en <= 1'b0;
		wait_code(fsre_pkg::AL_WDTO);
		chk({al_status, al_state}, {fsre_pkg::AL_WDTO, 4'h4});
		led_cnt(44, 16);
		wr(fsre_pkg::A_ALSTAT, 32'h0000_0000);
		@(posedge clk_sys);
		pdo_en <= 1'b1;
		req(fsre_pkg::RQ_OP);
		@(posedge clk_sys);
		sync_en <= 1'b0;
		wait_code(fsre_pkg::AL_SYNC);
		chk(al_status, fsre_pkg::AL_SYNC);
	endtask
	task automatic t_diag;
		logic [2:0] idx;
		repeat (9) pulse(7'h40);
		rd(fsre_pkg::A_DCNT);
		chk(q[3:0], fsre_pkg::DIAG_MAX);
		idx = q[6:4] - 3'h1;
		rd(8'h40 + {3'h0, idx, 2'b00});
		chk(q, {16'h0000, fsre_pkg::COMM_ERR_CODE});
		rd(8'h3C);
		chk(q, 32'h0000_0000);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ========================================
	// sequence and watchdog
	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		step;
		chk(al_state, fsre_pkg::RQ_INIT);
		t_trip;
		t_warn;
		t_remote;
		t_codes;
		t_wdtcfg;
		t_state;
		t_diag;
		summarize;
	end
	// the whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		summarize;
	end
endmodule
